//--- logic/vid_pkg.sv
// Constants shared by the vectored interrupt dispatcher
`default_nettype none

package vid_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_CH    = 96;
  localparam int unsigned CH_W      = 7;
  localparam int unsigned VEC_W     = 32;
  localparam int unsigned PRIO_W    = 3;
  localparam logic [6:0]  LAST_CH   = 7'h5f;
  localparam logic [6:0]  PHANTOM   = 7'h00;
  localparam logic [6:0]  TBL_OFS   = 7'h01;

  // ==========================================================
  // Reset values
  localparam logic [31:0] VEC_RST   = 32'h0000_0000;
  localparam logic [6:0]  CH_RST    = 7'h00;

  // ==========================================================
  // Default channel wiring of peripheral requests
  localparam int unsigned CH_ERR_HI   = 0;
  localparam int unsigned CH_TICK_CMP = 2;
  localparam int unsigned CH_TICK_OVF = 6;
  localparam int unsigned CH_TCP_L0   = 10;
  localparam int unsigned CH_TTU_L0   = 11;
  localparam int unsigned CH_BSP_L0   = 12;
  localparam int unsigned CH_LIN_L0   = 13;
  localparam int unsigned CH_CNV_EVT  = 14;
  localparam int unsigned CH_CNV_SW1  = 15;
  localparam int unsigned CH_CAN1_L0  = 16;
  localparam int unsigned CH_SP2_L0   = 17;
  localparam int unsigned CH_ERR_LO   = 20;
  localparam int unsigned CH_TCP_L1   = 24;
  localparam int unsigned CH_TTU_L1   = 25;
  localparam int unsigned CH_BSP_L1   = 26;
  localparam int unsigned CH_LIN_L1   = 27;
  localparam int unsigned CH_CNV_SW2  = 28;
  localparam int unsigned CH_CAN1_L1  = 29;
  localparam int unsigned CH_SP2_L1   = 30;
  localparam int unsigned CH_CNV_MAG  = 31;
  localparam int unsigned CH_CAN2_L0  = 35;
  localparam int unsigned CH_SP3_L0   = 37;
  localparam int unsigned CH_SP3_L1   = 38;
  localparam int unsigned CH_CAN2_L1  = 42;

  // ==========================================================
  // Dispatch stage states
  typedef enum logic [1:0] {
    VID_IDLE = 2'b01,
    VID_BUSY = 2'b10
  } vid_state_e;

endpackage

`default_nettype wire

//--- logic/vid_dispatcher.sv
// Vectored interrupt dispatcher: request wiring, arbitration, vector table
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Tracks ninety-six request channels
// - Per-channel priority and enable gate requests
// - Winning handler vector driven to core port
// - Index and vector also readable for software
// - Table entries stored and checked with parity
// - Location zero is phantom; channel 95 unusable
// - Channel n fetches table location n+1
// - High error request wired to channel 0
// - Low error request wired to channel 20
// - Tick compares 0..3 to channels 2..5
// - Tick overflows 0,1 to channels 6,7
// - Timer coprocessor to channels 10, 24
// - Timer transfer unit to channels 11, 25
// - Buffered serial port to channels 12, 26
// - LIN serial interface to channels 13, 27
// - Converter to channels 14, 15, 28, 31
// - First CAN to channels 16, 29
// - Second CAN to channels 35, 42
// - Serial ports to 17/30 and 37/38
module vid_dispatcher #(
  parameter int unsigned PRIO_W = vid_pkg::PRIO_W
) (
  input  wire logic                     mclk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     ce_i,
  input  wire logic                     err_high_i,
  input  wire logic                     err_low_i,
  input  wire logic [3:0]               tick_cmp_i,
  input  wire logic [1:0]               tick_ovf_i,
  input  wire logic [1:0]               tcp_req_i,
  input  wire logic [1:0]               ttu_req_i,
  input  wire logic [1:0]               bsp_req_i,
  input  wire logic [1:0]               lin_req_i,
  input  wire logic [3:0]               cnv_req_i,
  input  wire logic [1:0]               can1_req_i,
  input  wire logic [1:0]               can2_req_i,
  input  wire logic [1:0]               sp2_req_i,
  input  wire logic [1:0]               sp3_req_i,
  input  wire logic [95:0]              misc_req_i,
  input  wire logic [95:0]              chan_en_i,
  input  wire logic [96*PRIO_W-1:0]     chan_prio_i,
  input  wire logic                     tbl_we_i,
  input  wire logic [6:0]               tbl_addr_i,
  input  wire logic [31:0]              tbl_wdata_i,
  input  wire logic                     tbl_par_inv_i,
  output logic                          irq_o,
  output logic [31:0]                   vec_o,
  output logic [6:0]                    idx_o,
  output logic                          par_err_o
);

  // ==========================================================
  // Request wiring
  logic [95:0] req;
  logic [95:0] pend;

  always_comb begin
    req = misc_req_i;
    req[vid_pkg::CH_ERR_HI]  = req[vid_pkg::CH_ERR_HI]  | err_high_i;
    req[vid_pkg::CH_ERR_LO]  = req[vid_pkg::CH_ERR_LO]  | err_low_i;
    for (int k = 0; k < 4; k++) begin
      req[vid_pkg::CH_TICK_CMP+k] = req[vid_pkg::CH_TICK_CMP+k]
                                  | tick_cmp_i[k];
    end
    for (int k = 0; k < 2; k++) begin
      req[vid_pkg::CH_TICK_OVF+k] = req[vid_pkg::CH_TICK_OVF+k]
                                  | tick_ovf_i[k];
    end
    req[vid_pkg::CH_TCP_L0]  = req[vid_pkg::CH_TCP_L0]  | tcp_req_i[0];
    req[vid_pkg::CH_TCP_L1]  = req[vid_pkg::CH_TCP_L1]  | tcp_req_i[1];
    req[vid_pkg::CH_TTU_L0]  = req[vid_pkg::CH_TTU_L0]  | ttu_req_i[0];
    req[vid_pkg::CH_TTU_L1]  = req[vid_pkg::CH_TTU_L1]  | ttu_req_i[1];
    req[vid_pkg::CH_BSP_L0]  = req[vid_pkg::CH_BSP_L0]  | bsp_req_i[0];
    req[vid_pkg::CH_BSP_L1]  = req[vid_pkg::CH_BSP_L1]  | bsp_req_i[1];
    req[vid_pkg::CH_LIN_L0]  = req[vid_pkg::CH_LIN_L0]  | lin_req_i[0];
    req[vid_pkg::CH_LIN_L1]  = req[vid_pkg::CH_LIN_L1]  | lin_req_i[1];
    req[vid_pkg::CH_CNV_EVT] = req[vid_pkg::CH_CNV_EVT] | cnv_req_i[0];
    req[vid_pkg::CH_CNV_SW1] = req[vid_pkg::CH_CNV_SW1] | cnv_req_i[1];
    req[vid_pkg::CH_CNV_SW2] = req[vid_pkg::CH_CNV_SW2] | cnv_req_i[2];
    req[vid_pkg::CH_CNV_MAG] = req[vid_pkg::CH_CNV_MAG] | cnv_req_i[3];
    req[vid_pkg::CH_CAN1_L0] = req[vid_pkg::CH_CAN1_L0] | can1_req_i[0];
    req[vid_pkg::CH_CAN1_L1] = req[vid_pkg::CH_CAN1_L1] | can1_req_i[1];
    req[vid_pkg::CH_CAN2_L0] = req[vid_pkg::CH_CAN2_L0] | can2_req_i[0];
    req[vid_pkg::CH_CAN2_L1] = req[vid_pkg::CH_CAN2_L1] | can2_req_i[1];
    req[vid_pkg::CH_SP2_L0]  = req[vid_pkg::CH_SP2_L0]  | sp2_req_i[0];
    req[vid_pkg::CH_SP2_L1]  = req[vid_pkg::CH_SP2_L1]  | sp2_req_i[1];
    req[vid_pkg::CH_SP3_L0]  = req[vid_pkg::CH_SP3_L0]  | sp3_req_i[0];
    req[vid_pkg::CH_SP3_L1]  = req[vid_pkg::CH_SP3_L1]  | sp3_req_i[1];
  end

  // Last channel has no table slot, so it can never be dispatched
  always_comb begin
    pend = req & chan_en_i;
    pend[vid_pkg::LAST_CH] = 1'b0;
  end

  // ==========================================================
  // Arbitration: smaller priority value wins
  logic [6:0]        best_ch;
  logic [PRIO_W-1:0] best_lvl;
  logic              found;

  always_comb begin
    best_ch  = vid_pkg::CH_RST;
    best_lvl = '1;
    found    = 1'b0;
    for (int i = 0; i < vid_pkg::NUM_CH; i++) begin
      // Strict compare keeps the lower channel on a tie
      if (pend[i] && (!found || chan_prio_i[i*PRIO_W +: PRIO_W] < best_lvl))
      begin
        found    = 1'b1;
        best_ch  = 7'(i);
        best_lvl = chan_prio_i[i*PRIO_W +: PRIO_W];
      end
    end
  end

  logic [6:0] win_ch_r;
  logic       win_vld_r;
  logic [95:0] pend_q;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      win_ch_r  <= vid_pkg::CH_RST;
      win_vld_r <= 1'b0;
      pend_q    <= '0;
    end else if (ce_i) begin
      win_ch_r  <= best_ch;
      win_vld_r <= found;
      pend_q    <= pend;
    end
  end

  // ==========================================================
  // Vector table with one parity bit per entry
  function automatic logic par_of(input logic [31:0] d);
    par_of = ^d;
  endfunction

  logic [31:0] tbl_data [vid_pkg::NUM_CH];
  logic        tbl_par  [vid_pkg::NUM_CH];

  // Table contents are not reset; software loads them before use
  always_ff @(posedge mclk_i) begin
    if (ce_i && tbl_we_i && tbl_addr_i <= vid_pkg::LAST_CH) begin
      tbl_data[tbl_addr_i] <= tbl_wdata_i;
      tbl_par[tbl_addr_i]  <= par_of(tbl_wdata_i) ^ tbl_par_inv_i;
    end
  end

  logic [6:0]  fetch_addr;
  logic [31:0] ent;
  logic        ent_ok;
  logic        still;

  always_comb begin
    fetch_addr = win_ch_r + vid_pkg::TBL_OFS;
    ent        = tbl_data[fetch_addr];
    ent_ok     = (par_of(ent) == tbl_par[fetch_addr]);
    still      = win_vld_r && pend[win_ch_r];
  end

  // ==========================================================
  // Dispatch outputs
  vid_pkg::vid_state_e st_r;
  logic [31:0]         vec_r;
  logic [6:0]          idx_r;
  logic                perr_r;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_r   <= vid_pkg::VID_IDLE;
      vec_r  <= vid_pkg::VEC_RST;
      idx_r  <= vid_pkg::CH_RST;
      perr_r <= 1'b0;
    end else if (ce_i) begin
      perr_r <= still && !ent_ok;
      case (st_r)
        vid_pkg::VID_IDLE,
        vid_pkg::VID_BUSY: begin
          if (still && ent_ok) begin
            st_r  <= vid_pkg::VID_BUSY;
            vec_r <= ent;
            idx_r <= fetch_addr;
          end else begin
            // Stale or corrupt entries fall back to the phantom handler
            st_r  <= vid_pkg::VID_IDLE;
            vec_r <= tbl_data[vid_pkg::PHANTOM];
            idx_r <= vid_pkg::PHANTOM;
          end
        end
        default: begin
          st_r  <= vid_pkg::VID_IDLE;
          vec_r <= vid_pkg::VEC_RST;
          idx_r <= vid_pkg::CH_RST;
        end
      endcase
    end
  end

  assign irq_o     = (st_r == vid_pkg::VID_BUSY);
  assign vec_o     = vec_r;
  assign idx_o     = idx_r;
  assign par_err_o = perr_r;

  // ==========================================================
  // Checks
  property p_en_gate;
    @(posedge mclk_i) disable iff (!resetn_i)
    win_vld_r |-> pend_q[win_ch_r];
  endproperty
  a_en_gate: assert property (p_en_gate)
    else $error("winner was not an enabled request");

  property p_no_last;
    @(posedge mclk_i) disable iff (!resetn_i)
    win_vld_r |-> win_ch_r != vid_pkg::LAST_CH;
  endproperty
  a_no_last: assert property (p_no_last)
    else $error("last channel was dispatched");

  property p_fetch;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && still && ent_ok |=> irq_o && idx_o == $past(win_ch_r) + 7'h01;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("index is not channel plus one");

  property p_stale;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && win_vld_r && !pend[win_ch_r] |=> !irq_o && idx_o == 7'h00;
  endproperty
  a_stale: assert property (p_stale)
    else $error("withdrawn request still dispatched");

  property p_perr;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && still && !ent_ok |=> par_err_o && !irq_o;
  endproperty
  a_perr: assert property (p_perr)
    else $error("corrupt entry not flagged");

  property p_top;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && err_high_i && chan_en_i[0] && chan_prio_i[PRIO_W-1:0] == '0
      |=> win_vld_r && win_ch_r == 7'h00;
  endproperty
  a_top: assert property (p_top)
    else $error("channel 0 at top priority lost");

  property p_idle;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && pend == '0 ##1 ce_i |-> !win_vld_r ##1 !irq_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("dispatch with nothing pending");

  property p_irq_idx;
    @(posedge mclk_i) disable iff (!resetn_i)
    irq_o |-> idx_o != 7'h00 && !par_err_o;
  endproperty
  a_irq_idx: assert property (p_irq_idx)
    else $error("vector presented with phantom index");

  property p_perr_idx;
    @(posedge mclk_i) disable iff (!resetn_i)
    par_err_o |-> idx_o == 7'h00 && !irq_o;
  endproperty
  a_perr_idx: assert property (p_perr_idx)
    else $error("parity error shown with a live index");

  property p_par_store;
    @(posedge mclk_i) disable iff (!resetn_i)
    ce_i && tbl_we_i && !tbl_par_inv_i && tbl_addr_i <= vid_pkg::LAST_CH
      |=> tbl_par[$past(tbl_addr_i)] == par_of(tbl_data[$past(tbl_addr_i)]);
  endproperty
  a_par_store: assert property (p_par_store)
    else $error("stored parity does not match written entry");

  // A frozen block must keep presenting the same vector to the core
  property p_freeze;
    @(posedge mclk_i) disable iff (!resetn_i)
    !ce_i |=> $stable(vec_o) && $stable(idx_o) && $stable(irq_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while clock enable was low");

  property p_map_lo;
    @(posedge mclk_i) disable iff (!resetn_i)
    err_low_i && chan_en_i[vid_pkg::CH_ERR_LO] |-> pend[vid_pkg::CH_ERR_LO];
  endproperty
  a_map_lo: assert property (p_map_lo)
    else $error("low error request did not reach its channel");

  property p_map_cmp;
    @(posedge mclk_i) disable iff (!resetn_i)
    tick_cmp_i[3] && chan_en_i[vid_pkg::CH_TICK_CMP+3]
      |-> pend[vid_pkg::CH_TICK_CMP+3];
  endproperty
  a_map_cmp: assert property (p_map_cmp)
    else $error("last tick compare did not reach its channel");

endmodule

`default_nettype wire

//--- bench/vid_core_model.sv
// Processor core model that takes vectors from the dispatcher's port
`timescale 1ns/10ps
`default_nettype none

module vid_core_model (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        irq_i,
  input  wire logic [31:0] vec_i,
  input  wire logic [6:0]  idx_i,
  output logic [31:0]      taken_vec_o,
  output logic [6:0]       taken_idx_o
);
  // ==========================================================
  // Vector take
  // No acknowledge exists, so the core simply samples while irq is up
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      taken_vec_o <= 32'h0000_0000;
      taken_idx_o <= 7'h00;
    end else if (irq_i) begin
      taken_vec_o <= vec_i;
      taken_idx_o <= idx_i;
    end
  end
endmodule

`default_nettype wire

//--- bench/vid_dispatcher_tb.sv
// Self-checking bench for the vectored interrupt dispatcher
`timescale 1ns/10ps
`default_nettype none

module vid_dispatcher_tb;
  localparam int PW = vid_pkg::PRIO_W;

  logic             mclk_i      = 1'b0;
  logic             resetn_i    = 1'b0;
  logic             ce_i        = 1'b1;
  logic [27:0]      periph_r    = '0;
  logic [95:0]      misc_r      = '0;
  logic [95:0]      en_r        = '1;
  logic [96*PW-1:0] prio_r      = '0;
  logic             tbl_we_r    = 1'b0;
  logic [6:0]       tbl_addr_r  = '0;
  logic [31:0]      tbl_wdata_r = '0;
  logic             tbl_inv_r   = 1'b0;
  logic             irq_o;
  logic [31:0]      vec_o;
  logic [6:0]       idx_o;
  logic             par_err_o;
  logic [31:0]      core_vec;
  logic [6:0]       core_idx;
  int               errors          = 0;
  int               samples_checked = 0;
  // Peripheral bit order follows the port concatenation below
  int unsigned      map_ch [28] = '{0, 20, 2, 3, 4, 5, 6, 7, 10, 24, 11, 25,
    12, 26, 13, 27, 14, 15, 28, 31, 16, 29, 35, 42, 17, 30, 37, 38};

  always #5 mclk_i = ~mclk_i;

  vid_dispatcher #(.PRIO_W(PW)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .err_high_i(periph_r[0]), .err_low_i(periph_r[1]),
    .tick_cmp_i(periph_r[5:2]), .tick_ovf_i(periph_r[7:6]),
    .tcp_req_i(periph_r[9:8]), .ttu_req_i(periph_r[11:10]),
    .bsp_req_i(periph_r[13:12]), .lin_req_i(periph_r[15:14]),
    .cnv_req_i(periph_r[19:16]), .can1_req_i(periph_r[21:20]),
    .can2_req_i(periph_r[23:22]), .sp2_req_i(periph_r[25:24]),
    .sp3_req_i(periph_r[27:26]), .misc_req_i(misc_r),
    .chan_en_i(en_r), .chan_prio_i(prio_r), .tbl_we_i(tbl_we_r),
    .tbl_addr_i(tbl_addr_r), .tbl_wdata_i(tbl_wdata_r),
    .tbl_par_inv_i(tbl_inv_r), .irq_o(irq_o), .vec_o(vec_o),
    .idx_o(idx_o), .par_err_o(par_err_o));

  vid_core_model core (.mclk_i(mclk_i), .resetn_i(resetn_i), .irq_i(irq_o),
    .vec_i(vec_o), .idx_i(idx_o), .taken_vec_o(core_vec),
    .taken_idx_o(core_idx));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] tv(input logic [6:0] loc);
    return 32'hc0de_0000 | {25'h0, loc};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A miss must show the phantom entry, never a stale vector
  task automatic expect_out(input logic hit, input logic [6:0] loc,
                            input logic perr);
    check("irq_o", {31'h0, irq_o}, {31'h0, hit});
    check("idx_o", {25'h0, idx_o}, hit ? {25'h0, loc} : 32'h0);
    check("vec_o", vec_o, hit ? tv(loc) : tv(7'h00));
    check("par_err_o", {31'h0, par_err_o}, {31'h0, perr});
  endtask

  // Three edges cover the two-edge answer and the core model's sample on the third
  task automatic drive(input logic [27:0] p, input logic [95:0] m);
    @(posedge mclk_i);
    periph_r <= p;
    misc_r <= m;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic inv);
    @(posedge mclk_i);
    tbl_we_r <= 1'b1;
    tbl_addr_r <= a;
    tbl_wdata_r <= tv(a);
    tbl_inv_r <= inv;
    @(posedge mclk_i);
    tbl_we_r <= 1'b0;
    tbl_inv_r <= 1'b0;
  endtask

  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Walks a range of peripheral bits through the default wiring
  task automatic map_range(input int lo, input int hi);
    logic [6:0] loc;
    for (int i = lo; i <= hi; i++) begin
      loc = 7'(map_ch[i] + 1);
      drive(28'h1 << i, '0);
      expect_out(1'b1, loc, 1'b0);
      check("core_vec", core_vec, tv(loc));
      check("core_idx", {25'h0, core_idx}, {25'h0, loc});
    end
  endtask

  task automatic t_map();
    map_range(0, 0);
    map_range(1, 1);
    map_range(2, 5);
    map_range(6, 7);
    map_range(8, 9);
    map_range(10, 11);
    map_range(12, 13);
    map_range(14, 15);
    map_range(16, 19);
    map_range(20, 21);
    map_range(22, 23);
    map_range(24, 27);
  endtask

  task automatic t_edges();
    drive('0, 96'h1 << 94);
    expect_out(1'b1, 7'h5f, 1'b0);
    drive('0, 96'h1 << 95);
    expect_out(1'b0, 7'h00, 1'b0);
  endtask

  task automatic t_prio();
    @(posedge mclk_i);
    prio_r[40*PW +: PW] <= PW'(1);
    drive('0, (96'h1 << 40) | (96'h1 << 70));
    expect_out(1'b1, 7'h47, 1'b0);
    @(posedge mclk_i);
    prio_r[40*PW +: PW] <= PW'(0);
    drive('0, (96'h1 << 40) | (96'h1 << 70));
    expect_out(1'b1, 7'h29, 1'b0);
    @(posedge mclk_i);
    en_r[40] <= 1'b0;
    drive('0, (96'h1 << 40) | (96'h1 << 70));
    expect_out(1'b1, 7'h47, 1'b0);
    @(posedge mclk_i);
    en_r[70] <= 1'b0;
    drive('0, (96'h1 << 40) | (96'h1 << 70));
    expect_out(1'b0, 7'h00, 1'b0);
    @(posedge mclk_i);
    en_r <= '1;
  endtask

  task automatic t_withdraw();
    drive('0, 96'h1 << 33);
    expect_out(1'b1, 7'h22, 1'b0);
    drive('0, '0);
    expect_out(1'b0, 7'h00, 1'b0);
  endtask

  task automatic t_parity();
    wr(7'h33, 1'b1);
    drive('0, 96'h1 << 50);
    expect_out(1'b0, 7'h00, 1'b1);
    drive('0, '0);
    wr(7'h33, 1'b0);
    drive('0, 96'h1 << 50);
    expect_out(1'b1, 7'h33, 1'b0);
    drive('0, '0);
  endtask

  // Clock enable low must freeze outputs and ignore table writes
  task automatic t_freeze();
    drive('0, 96'h1 << 33);
    expect_out(1'b1, 7'h22, 1'b0);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    misc_r <= 96'h1 << 60;
    wr(7'h22, 1'b1);
    repeat (2) @(posedge mclk_i);
    #1;
    expect_out(1'b1, 7'h22, 1'b0);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    drive('0, 96'h1 << 60);
    expect_out(1'b1, 7'h3d, 1'b0);
    drive('0, 96'h1 << 33);
    expect_out(1'b1, 7'h22, 1'b0);
    drive('0, '0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    #1;
    // Reset clears the vector to zero, not to the phantom entry
    check("irq_o", {31'h0, irq_o}, 32'h0);
    check("idx_o", {25'h0, idx_o}, 32'h0);
    check("par_err_o", {31'h0, par_err_o}, 32'h0);
    check("vec_o", vec_o, 32'h0000_0000);
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    // The table has no reset, so every location is loaded first
    for (int a = 0; a < 96; a++) begin
      wr(7'(a), 1'b0);
    end
    t_map();
    t_edges();
    t_prio();
    t_withdraw();
    t_parity();
    t_freeze();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    stop_test();
  end
endmodule

`default_nettype wire
